/* File: odasm_consts.svh */
`ifndef ODASM_CONSTS_SVH
`define ODASM_CONSTS_SVH

// slots: 0 basic, 1..3 expansion
`define ODASM_NSLOT         4
`define ODASM_DI_PER_SLOT   3
`define ODASM_DO_PER_SLOT   2
`define ODASM_NDRV          8
`define ODASM_IMG_BYTES     16
// input image byte offsets
`define ODASM_HW_OFS        4'hc
`define ODASM_HW_LAST       4'he
`define ODASM_FAULT_OFS     4'hf
// slot-skip selector decode
`define ODASM_SKIP_MASK     4'h3
`define ODASM_SKIP_NONE     2'h0
`define ODASM_SKIP_ONE      2'h1
`define ODASM_SKIP_TWO      2'h2
`define ODASM_SKIP_BAD      2'h3
`define ODASM_LAST_SLOT     3'h3
// reset values
`define ODASM_BYTE_ZERO     8'h00
`define ODASM_FAULT_RST     8'h00

`endif

/* File: odasm_drv_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface odasm_drv_if;
    odasm_pkg::odasm_byte_t do_req;
    odasm_pkg::odasm_byte_t do_out;
    logic                   oc_pin;
    logic                   ot_pin;
    logic                   detect_en;
    logic                   fault;

    modport guard (input do_req, input oc_pin, input ot_pin, input detect_en,
                   output do_out, output fault);
    modport core  (output do_req, output oc_pin, output ot_pin, output detect_en,
                   input do_out, input fault);
endinterface : odasm_drv_if

`default_nettype wire

/* File: odasm_guard.sv */
`timescale 1ns/1ps
`default_nettype none
`include "odasm_consts.svh"

module odasm_guard (
    input  wire logic  clock,
    input  wire logic  rst_n,
    odasm_drv_if.guard drv
);
    logic [2:0]                    oc_sync;
    logic [2:0]                    ot_sync;
    logic                          oc_q;
    logic                          ot_q;
    odasm_pkg::odasm_drv_state_e   state;
    odasm_pkg::odasm_drv_state_e   next_state;

    // pin samplers, a change counts once stages two and three agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oc_sync <= 3'h0;
            ot_sync <= 3'h0;
        end else begin
            oc_sync <= {oc_sync[1:0], drv.oc_pin};
            ot_sync <= {ot_sync[1:0], drv.ot_pin};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oc_q <= 1'b0;
            ot_q <= 1'b0;
        end else begin
            if (oc_sync[1] == oc_sync[2]) oc_q <= oc_sync[2]; // R1
            if (ot_sync[1] == ot_sync[2]) ot_q <= ot_sync[2]; // R1
        end
    end

    always_comb begin
        case (state)
            odasm_pkg::ODASM_DRV_NORMAL:
                next_state = (drv.detect_en && (oc_q || ot_q)) ? // R1 R6
                             odasm_pkg::ODASM_DRV_SHUTDOWN : odasm_pkg::ODASM_DRV_NORMAL;
            odasm_pkg::ODASM_DRV_SHUTDOWN:
                next_state = (drv.detect_en && (oc_q || ot_q)) ? // R2
                             odasm_pkg::ODASM_DRV_SHUTDOWN : odasm_pkg::ODASM_DRV_NORMAL;
            default:
                next_state = odasm_pkg::ODASM_DRV_NORMAL;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= odasm_pkg::ODASM_DRV_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drv.do_out <= `ODASM_BYTE_ZERO;
            drv.fault  <= 1'b0;
        end else begin
            drv.do_out <= (next_state == odasm_pkg::ODASM_DRV_SHUTDOWN) ?
                          `ODASM_BYTE_ZERO : drv.do_req; // R2
            drv.fault  <= (next_state == odasm_pkg::ODASM_DRV_SHUTDOWN); // R17
        end
    end
endmodule : odasm_guard

`default_nettype wire

/* File: odasm_host.sv */
`timescale 1ns/1ps
`default_nettype none

module odasm_host (
    input  wire logic        clock,
    input  wire logic [7:0]  img_data,
    output logic      [3:0]  img_addr,
    output logic      [63:0] output_image_base
);
    initial begin
        img_addr = 4'h0;
        output_image_base = 64'h0;
    end
    // whole 16-byte image addressed, fault byte included
    task automatic read_byte(input logic [3:0] a, output logic [7:0] d);
        @(negedge clock);
        img_addr = a;
        @(negedge clock);
        d = img_data;
    endtask : read_byte
    task automatic set_image(input logic [63:0] v);
        @(negedge clock);
        output_image_base = v;
    endtask : set_image
endmodule : odasm_host

`default_nettype wire

/* File: odasm_pkg.sv */
`default_nettype none

package odasm_pkg;
    typedef enum logic [1:0] {
        ODASM_KIND_GENERAL,
        ODASM_KIND_HIGH_CURRENT,
        ODASM_KIND_ANALOG
    } odasm_kind_e;

    typedef enum logic {
        ODASM_DRV_NORMAL,
        ODASM_DRV_SHUTDOWN
    } odasm_drv_state_e;

    typedef logic [7:0] odasm_byte_t;
endpackage : odasm_pkg

`default_nettype wire

/* File: odasm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "odasm_consts.svh"

// Operation
// (R1) Every byte-wide output driver watches its own overcurrent and overtemperature sense.
// (R2) A faulting driver forces its whole byte off and holds it off until the cause is gone.
// (R3) Shutdown of a driver leaves all other functions and the image read path running.
// (R4) Input image byte 15 reports driver faults, a one meaning that driver is in alarm.
// (R5) Fault bit k belongs to output byte k, two bits per slot from basic to expansion 3.
// (R6) Slots with a high-current output or analog input module do no fault detection.
// (R7) The configuration keeps special modules out of slot 1 when the handwheel is needed.
// (R8) A slot with a high-current output module leaves its three input bytes unused.
// (R9) Input areas of the other slots stay at their fixed byte positions.
// (R10) Skip selector value 0 is the default and omits no preceding module.
// (R11) Skip selector value 1 moves a module up by one omitted predecessor.
// (R12) Skip selector value 2 moves a module up by two omitted predecessors.
// (R13) The configuration never sets the skip selector to the prohibited value 3.
// (R14) Only the low two selector bits are decoded, so higher values alias to 0 to 3.
// (R15) Of several units with a handwheel interface only the one closest to the host enables it.
// (R16) The host reserves the fault byte and allocates input space in 16-byte units.
// (R17) A fault bit stays set through the shutdown and clears when the fault has gone.
module odasm_top (
    input  wire logic         clock,
    input  wire logic         rst_n,
    // physical module positions 1..3: kind and skip selector
    input  wire logic [5:0]   exp_kind,
    input  wire logic [11:0]  exp_skip_sel,
    // input pins per physical position, three bytes each
    input  wire logic [95:0]  di_pin,
    input  wire logic [23:0]  hw_pin,
    input  wire logic         hw_present,
    input  wire logic         hw_closer_enabled,
    // output image from the host, logical bytes 0..7
    input  wire logic [63:0]  output_image_base,
    // driver sense pins per physical output byte
    input  wire logic [7:0]   drv_overcurrent,
    input  wire logic [7:0]   drv_overtemp,
    // input image read port
    input  wire logic [3:0]   img_addr,
    output logic      [7:0]   img_data,
    output logic      [7:0]   output_driver_fault_status,
    output logic      [63:0]  do_pin,
    output logic              handwheel_enable
);
    logic [95:0] di_s1;
    logic [95:0] di_s2;
    logic [95:0] di_s3;
    logic [95:0] di_q;
    logic [23:0] hw_s1;
    logic [23:0] hw_s2;
    logic [23:0] hw_s3;
    logic [23:0] hw_q;
    logic [7:0]  phys_fault;
    logic [63:0] phys_out;

    logic [1:0]              slot_of   [`ODASM_NSLOT];
    logic                    slot_ok   [`ODASM_NSLOT];
    odasm_pkg::odasm_kind_e  kind_of   [`ODASM_NSLOT];
    logic [1:0]              src_of    [`ODASM_NSLOT];
    logic                    filled    [`ODASM_NSLOT];
    logic [`ODASM_NDRV-1:0]  next_fault;
    odasm_pkg::odasm_byte_t  image     [`ODASM_IMG_BYTES];
    logic                    next_hw_en;

    // low two selector bits only; 3 leaves the module unmapped
    function automatic logic [2:0] odasm_place(input logic [1:0] pos, input logic [3:0] sel);
        logic [1:0] skip;
        logic [2:0] slot;
        skip = 2'(sel & `ODASM_SKIP_MASK); // R14
        slot = {1'b0, pos} + {1'b0, skip}; // R10 R11 R12
        if (skip == `ODASM_SKIP_BAD || slot > `ODASM_LAST_SLOT) begin // R13
            odasm_place = 3'h0;
        end else begin
            odasm_place = {1'b1, slot[1:0]};
        end
    endfunction : odasm_place

    // input pin samplers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            di_s1 <= 96'h0;
            di_s2 <= 96'h0;
            di_s3 <= 96'h0;
            hw_s1 <= 24'h0;
            hw_s2 <= 24'h0;
            hw_s3 <= 24'h0;
        end else begin
            di_s1 <= di_pin;
            di_s2 <= di_s1;
            di_s3 <= di_s2;
            hw_s1 <= hw_pin;
            hw_s2 <= hw_s1;
            hw_s3 <= hw_s2;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            di_q <= 96'h0;
            hw_q <= 24'h0;
        end else begin
            di_q <= (di_s2 & di_s3) | (di_q & (di_s2 ^ di_s3));
            hw_q <= (hw_s2 & hw_s3) | (hw_q & (hw_s2 ^ hw_s3));
        end
    end

    // placement of physical modules into logical slots
    always_comb begin
        logic [2:0] pl;
        pl = 3'h0;
        for (int p = 0; p < `ODASM_NSLOT; p++) begin
            slot_of[p] = 2'(p);
            slot_ok[p] = 1'b1;
            kind_of[p] = odasm_pkg::ODASM_KIND_GENERAL;
            src_of[p]  = 2'(p);
            filled[p]  = (p == 0);
        end
        for (int p = 1; p < `ODASM_NSLOT; p++) begin
            pl = odasm_place(2'(p), exp_skip_sel[4*(p-1) +: 4]);
            slot_ok[p] = pl[2];
            slot_of[p] = pl[1:0];
        end
        for (int p = 1; p < `ODASM_NSLOT; p++) begin
            if (slot_ok[p]) begin
                kind_of[slot_of[p]] = odasm_pkg::odasm_kind_e'(exp_kind[2*(p-1) +: 2]);
                src_of[slot_of[p]]  = 2'(p);
                filled[slot_of[p]]  = 1'b1;
            end
        end
    end

    // byte-wide driver guards, one per physical output byte
    generate
        for (genvar g = 0; g < `ODASM_NDRV; g++) begin : g_drv
            odasm_drv_if drv_bus ();
            localparam int P = g / `ODASM_DO_PER_SLOT;
            localparam int J = g % `ODASM_DO_PER_SLOT;

            assign drv_bus.oc_pin    = drv_overcurrent[g];
            assign drv_bus.ot_pin    = drv_overtemp[g];
            assign drv_bus.detect_en = slot_ok[P] && filled[slot_of[P]] &&
                                       kind_of[slot_of[P]] == odasm_pkg::ODASM_KIND_GENERAL; // R6
            assign drv_bus.do_req    = slot_ok[P] ?
                output_image_base[8*(`ODASM_DO_PER_SLOT*slot_of[P] + J) +: 8] : `ODASM_BYTE_ZERO;
            assign phys_fault[g]     = drv_bus.fault;
            assign phys_out[8*g +: 8] = drv_bus.do_out;

            odasm_guard u_guard (
                .clock (clock),
                .rst_n (rst_n),
                .drv   (drv_bus.guard)
            );
        end
    endgenerate

    // fault bits in logical byte order
    always_comb begin
        next_fault = `ODASM_FAULT_RST;
        for (int s = 0; s < `ODASM_NSLOT; s++) begin
            for (int j = 0; j < `ODASM_DO_PER_SLOT; j++) begin
                if (filled[s] && kind_of[s] == odasm_pkg::ODASM_KIND_GENERAL) begin // R6
                    next_fault[`ODASM_DO_PER_SLOT*s + j] =
                        phys_fault[`ODASM_DO_PER_SLOT*src_of[s] + j]; // R5
                end
            end
        end
    end

    // input image assembly
    always_comb begin
        for (int b = 0; b < `ODASM_IMG_BYTES; b++) begin
            image[b] = `ODASM_BYTE_ZERO;
        end
        for (int s = 0; s < `ODASM_NSLOT; s++) begin
            for (int j = 0; j < `ODASM_DI_PER_SLOT; j++) begin
                if (filled[s] && kind_of[s] != odasm_pkg::ODASM_KIND_HIGH_CURRENT) begin // R8
                    image[`ODASM_DI_PER_SLOT*s + j] =
                        di_q[8*(`ODASM_DI_PER_SLOT*src_of[s] + j) +: 8]; // R9
                end
            end
        end
        for (int j = 0; j < `ODASM_DI_PER_SLOT; j++) begin
            if (handwheel_enable) begin
                image[`ODASM_HW_OFS + 4'(j)] = hw_q[8*j +: 8];
            end
        end
        image[`ODASM_FAULT_OFS] = output_driver_fault_status; // R4
    end

    // handwheel interface only when no closer unit has one
    assign next_hw_en = hw_present && !hw_closer_enabled && filled[1] &&
                        kind_of[1] == odasm_pkg::ODASM_KIND_GENERAL; // R15 R7

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            output_driver_fault_status <= `ODASM_FAULT_RST;
        end else begin
            output_driver_fault_status <= next_fault; // R4 R17
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            img_data <= `ODASM_BYTE_ZERO;
        end else begin
            img_data <= image[img_addr]; // R3
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            do_pin <= 64'h0;
        end else begin
            do_pin <= phys_out; // R2
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            handwheel_enable <= 1'b0;
        end else begin
            handwheel_enable <= next_hw_en;
        end
    end
endmodule : odasm_top

`default_nettype wire

/* File: odasm_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module odasm_top_bench;
    logic        clock, rst_n, hw_present, hw_closer_enabled, handwheel_enable;
    logic [5:0]  exp_kind;
    logic [11:0] exp_skip_sel;
    logic [95:0] di_pin;
    logic [23:0] hw_pin;
    logic [63:0] output_image_base, do_pin, img;
    logic [7:0]  drv_overcurrent, drv_overtemp, img_data, output_driver_fault_status, rd;
    logic [3:0]  img_addr;
    int          errors = 0, compares = 0, k, s, b, l;

    odasm_top i_dut (.clock, .rst_n, .exp_kind, .exp_skip_sel, .di_pin, .hw_pin, .hw_present,
        .hw_closer_enabled, .output_image_base, .drv_overcurrent, .drv_overtemp, .img_addr,
        .img_data, .output_driver_fault_status, .do_pin, .handwheel_enable);
    odasm_host i_host (.clock, .img_data, .img_addr, .output_image_base);

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask : wt

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        #200000;
        errors++;
        tally_and_finish;
    end

    initial begin
        rst_n = 1'b0;
        exp_kind = 6'h00;
        exp_skip_sel = 12'h000;
        hw_present = 1'b0;
        hw_closer_enabled = 1'b0;
        hw_pin = 24'h5a3c96;
        drv_overcurrent = 8'h00;
        drv_overtemp = 8'h00;
        img = 64'h8877665544332211;
        for (b = 0; b < 12; b++) di_pin[8*b+:8] = 8'ha0 + 8'(b);
        repeat (20) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        chk(output_driver_fault_status, 64'h0);
        i_host.set_image(img);
        wt(4);
        chk(do_pin, img);
        // one driver at a time, both sense kinds
        for (k = 0; k < 8; k++) begin
            if (k % 2) drv_overtemp[k] = 1'b1;
            else drv_overcurrent[k] = 1'b1;
            wt(8);
            chk(output_driver_fault_status, 64'h1 << k);
            chk(do_pin, img & ~(64'hff << 8 * k));
            i_host.read_byte(4'hf, rd);
            chk(rd, 64'h1 << k);
            i_host.read_byte(4'h1, rd);
            chk(rd, di_pin[15:8]);
            drv_overtemp = 8'h00;
            drv_overcurrent = 8'h00;
            wt(8);
            chk(output_driver_fault_status, 64'h0);
            chk(do_pin, img);
        end
        // high-current then analog module in slot 2
        for (k = 1; k < 3; k++) begin
            exp_kind = 6'(k << 2);
            drv_overcurrent = 8'h10;
            wt(10);
            chk(output_driver_fault_status, 64'h0);
            for (b = 6; b < 12; b++) begin
                i_host.read_byte(4'(b), rd);
                chk(rd, (k == 1 && b < 9) ? 8'h00 : di_pin[8*b+:8]);
            end
            drv_overcurrent = 8'h00;
        end
        exp_kind = 6'h00;
        // slots 2 and 3 modules unmapped, slot 1 module walked by its selector
        exp_skip_sel[11:4] = 8'h33;
        for (s = 0; s < 16; s++) begin
            exp_skip_sel[3:0] = 4'(s);
            wt(6);
            l = 1 + s % 4;
            for (b = 3; b < 12; b++) begin
                i_host.read_byte(4'(b), rd);
                chk(rd, (b / 3 == l) ? di_pin[8*(3+b%3)+:8] : 8'h00);
            end
            chk(do_pin[63:16], (l > 3) ? 48'h0 : {32'h0, img[16*(l%4)+:16]});
        end
        exp_skip_sel = 12'h000;
        // handwheel on with a general module in slot 1, then off once a closer unit has it enabled
        hw_present = 1'b1;
        wt(6);
        chk(handwheel_enable, 64'h1);
        i_host.read_byte(4'hc, rd);
        chk(rd, hw_pin[7:0]);
        hw_closer_enabled = 1'b1;
        wt(4);
        chk(handwheel_enable, 64'h0);
        i_host.read_byte(4'hc, rd);
        chk(rd, 64'h0);
        tally_and_finish;
    end
endmodule : odasm_top_bench

`default_nettype wire

/* File: odasm_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module odasm_top_chk (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [5:0]  exp_kind,
    input wire logic [11:0] exp_skip_sel,
    input wire logic        hw_present,
    input wire logic        hw_closer_enabled,
    input wire logic [7:0]  drv_overcurrent,
    input wire logic [7:0]  drv_overtemp,
    input wire logic [3:0]  img_addr,
    input wire logic [7:0]  img_data,
    input wire logic [7:0]  output_driver_fault_status,
    input wire logic [63:0] do_pin,
    input wire logic        handwheel_enable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic cfg0;
    logic hc2;
    logic f0;
    assign cfg0 = (exp_kind == 6'h00) && (exp_skip_sel == 12'h000);
    assign hc2  = (exp_kind[3:2] == 2'h1) && (exp_skip_sel == 12'h000);
    assign f0   = drv_overcurrent[0] | drv_overtemp[0];

    // sense to output takes six edges, seen one sample later
    fault_off_a: assert property ((cfg0 && f0)[*6] |=> do_pin[7:0] == 8'h00)
        else $error("byte 0 driven in fault");
    fault_set_a: assert property ((cfg0 && f0)[*6] |=> output_driver_fault_status[0])
        else $error("fault bit 0 not set");
    fault_clear_a: assert property ((cfg0 && !f0)[*6] |=> !output_driver_fault_status[0])
        else $error("fault bit 0 stuck");
    fault_read_a: assert property (img_addr == 4'hf ##1 $stable(output_driver_fault_status)
        |-> img_data == output_driver_fault_status)
        else $error("fault byte read wrong");
    special_nodet_a: assert property (hc2 [*6] |-> output_driver_fault_status[5:4] == 2'h0)
        else $error("special slot reports fault");
    unused_di_a: assert property (hc2 [*6] ##0 (img_addr >= 4'h6 && img_addr <= 4'h8)
        |=> img_data == 8'h00)
        else $error("unused input area not zero");
    unmapped_do_a: assert property ((exp_skip_sel[9:8] == 2'h3)[*4] |-> do_pin[63:48] == 16'h0)
        else $error("unmapped module drives outputs");
    hw_near_a: assert property (hw_closer_enabled |=> !handwheel_enable)
        else $error("handwheel enabled behind nearer unit");
    hw_on_a: assert property ((hw_present && !hw_closer_enabled && cfg0)[*2]
        |=> handwheel_enable)
        else $error("handwheel not enabled");
endmodule : odasm_top_chk

bind odasm_top odasm_top_chk i_chk (.clock, .rst_n, .exp_kind, .exp_skip_sel, .hw_present,
    .hw_closer_enabled, .drv_overcurrent, .drv_overtemp, .img_addr, .img_data,
    .output_driver_fault_status, .do_pin, .handwheel_enable);

`default_nettype wire
